/* acq_trigger.v */
// trigger qualification, scan clock and period counter with an axi4-lite register slave
// Operation
// [RULE_01] pulse trigger source is channel one or the pulse input, by configuration
// [RULE_02] after a crossing a width timer qualifies the pulse trigger
// [RULE_03] maximum mode fires on early recross; minimum fires when no recross in width
// [RULE_04] equal and not-equal compare each of 16 lines, don't-care lines excluded
// [RULE_05] equal fires on exact match; not-equal fires on any other combination
// [RULE_06] greater and less treat the lines as one unsigned value versus threshold
// [RULE_07] scan clock source is the internal rate or the external clock
// [RULE_08] with external clock a scan starts only after a rising edge
// [RULE_09] external clock can be prescaled by an integer from 1 to 255
// [RULE_10] a 32-bit counter measures and reports the external clock period
// [RULE_11] latest period count is available in every scan
// [RULE_12] two enabled 16-bit words; low word placed before high word
// [RULE_13] low word only shortens the least scan period by one microsecond
// [RULE_14] software uses low word only above 305 Hz; not enforced here
// [RULE_15] pulse width setting spans 100 ns up to 800 ms
// [RULE_16] pre/post mode acts on trigger after scan ends; rate changes after next scan
// [RULE_17] period counts 20 MHz timebase ticks between external edges, captured per edge; ticks here come every 6 cycles of 125 MHz, about 20.8 MHz
// [RULE_18] prescale N starts one scan per N qualifying external edges
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "trig_map.vh"
module acq_trigger #(
  parameter WIDTH_MAX_CYC = `WIDTH_MAX_MS * 1000 * `CLK_MHZ
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ch1_above,
  input  wire        pulse_above,
  input  wire [15:0] dig_in,
  input  wire        ext_clk,
  input  wire        scan_done,
  output reg         scan_start,
  output reg         trigger,
  output reg         post_rate,
  output reg  [15:0] period_count_low_word,
  output reg  [15:0] period_count_high_word,
  output reg  [1:0]  scan_words
);
  localparam WIDTH_MIN_CYC = (`WIDTH_MIN_NS * `CLK_MHZ + 999) / 1000;
  // whole cycles per timebase tick; 125/20 rounds down to 6, so ticks run slightly fast
  localparam TB_DIV        = `CLK_MHZ / `TB_MHZ;
  localparam WORD_CYC      = `SCAN_WORD_NS * `CLK_MHZ / 1000;
  localparam P_IDLE = 2'd0;
  localparam P_TIME = 2'd1;
  localparam P_WAIT = 2'd2;

  reg [31:0] ctrl_q, pattern_q, care_q, width_q, int_div_q, pre_div_q, post_div_q;
  reg [31:0] per_cnt_q, period_q;
  reg [31:0] width_cnt_q, rate_cnt_q;
  reg [7:0]  edge_cnt_q;
  reg [6:0]  tb_cnt_q;
  reg [1:0]  pstate_q;
  reg        ch1_s1_q, ch1_s2_q, pul_s1_q, pul_s2_q, lvl_q;
  reg [15:0] dig_s1_q, dig_s2_q;
  reg        ext_s1_q, ext_s2_q, ext_q;
  reg        trig_pend_q, busy_q, post_next_q;
  reg        aw_ok_q, w_ok_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  wire       lvl, ext_rise, tb_tick, cond_hit, pulse_hit, ext_scan, int_scan, scan_go;
  wire [31:0] width_cyc, div_now;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0]  be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i]) merge[i*8 +: 8] = din[i*8 +: 8];
    end
  endfunction

  function [31:0] clamp;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // every asynchronous input goes through two flops first
  always @(posedge aclk) begin
    ch1_s1_q <= ch1_above;
    ch1_s2_q <= ch1_s1_q;
    pul_s1_q <= pulse_above;
    pul_s2_q <= pul_s1_q;
    dig_s1_q <= dig_in;
    dig_s2_q <= dig_s1_q;
    ext_s1_q <= ext_clk;
    ext_s2_q <= ext_s1_q;
  end

  assign lvl      = ctrl_q[`CTRL_PULSE_SRC] ? pul_s2_q : ch1_s2_q; // RULE_01
  assign ext_rise = ext_s2_q & ~ext_q;
  assign tb_tick  = (tb_cnt_q == TB_DIV[6:0] - 7'd1);
  // width held inside the documented span
  assign width_cyc = clamp(width_q, WIDTH_MIN_CYC, WIDTH_MAX_CYC); // RULE_15

  // pulse qualification after the threshold crossing
  assign pulse_hit = ctrl_q[`CTRL_PULSE_MAX]
    ? (pstate_q == P_TIME && !lvl && lvl_q) // RULE_03
    : (pstate_q == P_TIME && lvl && width_cnt_q >= width_cyc - 32'd1); // RULE_03

  reg pat_hit;
  always @* begin
    case (ctrl_q[`CTRL_PAT_COND])
      `COND_EQ: pat_hit = ((dig_s2_q ^ pattern_q[15:0]) & care_q[15:0]) == 16'h0000; // RULE_04
      `COND_NE: pat_hit = ((dig_s2_q ^ pattern_q[15:0]) & care_q[15:0]) != 16'h0000; // RULE_05
      `COND_GT: pat_hit = dig_s2_q > pattern_q[15:0]; // RULE_06
      default:  pat_hit = dig_s2_q < pattern_q[15:0]; // RULE_06
    endcase
  end

  assign cond_hit = (ctrl_q[`CTRL_TRIG_TYPE] == `TT_PULSE) ? pulse_hit :
                    (ctrl_q[`CTRL_TRIG_TYPE] == `TT_PATTERN) ? pat_hit : 1'b0;

  // scan pacing: prescaled external edges or internal divider
  assign ext_scan = ext_rise && (edge_cnt_q + 8'd1 >= ctrl_q[`CTRL_PRESCALE]); // RULE_08 RULE_18
  assign div_now  = post_rate ? post_div_q : pre_div_q;
  assign int_scan = (rate_cnt_q + 32'd1 >= div_now);
  assign scan_go  = ctrl_q[`CTRL_ARM] && !busy_q &&
                    (ctrl_q[`CTRL_EXT_CLK] ? ext_scan : int_scan); // RULE_07

  always @(posedge aclk) begin
    if (!aresetn) begin
      pstate_q    <= P_IDLE;
      lvl_q       <= 1'b0;
      width_cnt_q <= 32'h0000_0000;
      ext_q       <= 1'b0;
      tb_cnt_q    <= 7'h00;
      per_cnt_q   <= 32'h0000_0000;
      period_q    <= 32'h0000_0000;
      edge_cnt_q  <= 8'h00;
      rate_cnt_q  <= 32'h0000_0000;
      trig_pend_q <= 1'b0;
      busy_q      <= 1'b0;
      post_next_q <= 1'b0;
      scan_start  <= 1'b0;
      trigger     <= 1'b0;
      post_rate   <= 1'b0;
      period_count_low_word  <= 16'h0000;
      period_count_high_word <= 16'h0000;
      scan_words  <= 2'b00;
    end else begin
      lvl_q <= lvl;
      ext_q <= ext_s2_q;
      scan_start <= 1'b0;
      trigger <= 1'b0;
      case (pstate_q)
        P_IDLE: if (lvl && !lvl_q) begin
          pstate_q    <= P_TIME; // RULE_02
          width_cnt_q <= 32'h0000_0000;
        end
        P_TIME: begin
          width_cnt_q <= width_cnt_q + 32'd1;
          if (pulse_hit || !lvl || width_cnt_q >= width_cyc - 32'd1)
            pstate_q <= lvl ? P_WAIT : P_IDLE; // RULE_02
        end
        P_WAIT: if (!lvl) pstate_q <= P_IDLE;
        default: pstate_q <= P_IDLE;
      endcase
      // 20 MHz enable, then period of the external clock in those ticks
      tb_cnt_q <= tb_tick ? 7'h00 : tb_cnt_q + 7'd1;
      if (ext_rise) begin
        period_q  <= per_cnt_q; // RULE_10 RULE_17
        per_cnt_q <= 32'h0000_0000;
      end else if (tb_tick) begin
        per_cnt_q <= per_cnt_q + 32'd1; // RULE_17
      end
      if (ext_rise)
        edge_cnt_q <= ext_scan ? 8'h00 : edge_cnt_q + 8'd1; // RULE_09
      rate_cnt_q <= int_scan ? 32'h0000_0000 : rate_cnt_q + 32'd1;
      if (cond_hit && ctrl_q[`CTRL_ARM])
        trig_pend_q <= 1'b1;
      if (scan_done)
        busy_q <= 1'b0;
      if (scan_go) begin
        scan_start <= 1'b1;
        busy_q     <= 1'b1;
        // latest period rides along with every scan, low word first
        // an edge-paced scan takes the period that this very edge closes
        period_count_low_word  <= ext_rise ? per_cnt_q[15:0] : period_q[15:0]; // RULE_11 RULE_12
        period_count_high_word <= ext_rise ? per_cnt_q[31:16] : period_q[31:16]; // RULE_11
        scan_words <= {ctrl_q[`CTRL_HI_EN], ctrl_q[`CTRL_LO_EN]}; // RULE_12 RULE_13
        if (post_next_q)
          post_rate <= 1'b1; // RULE_16
      end
      // in pre/post mode the trigger waits for the running scan to finish
      if (trig_pend_q && (!ctrl_q[`CTRL_PREPOST] || !busy_q || scan_done)) begin
        trigger     <= 1'b1; // RULE_16
        trig_pend_q <= 1'b0;
        post_next_q <= 1'b1;
      end
      if (!ctrl_q[`CTRL_ARM]) begin
        post_next_q <= 1'b0;
        post_rate   <= 1'b0;
        trig_pend_q <= 1'b0;
      end
    end
  end

  // axi4-lite slave: address and data taken in either order, response after both
  wire [7:0]  wa = aw_ok_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_ok_q ? wdata_q : s_axi_wdata;
  wire [3:0]  ws = w_ok_q ? wstrb_q : s_axi_wstrb;
  wire        aw_has = aw_ok_q || (s_axi_awvalid && s_axi_awready);
  wire        w_has  = w_ok_q || (s_axi_wvalid && s_axi_wready);
  wire        do_wr  = aw_has && w_has && !s_axi_bvalid;
  wire        wmap   = (wa <= `OFF_POST_DIV) && (wa[1:0] == 2'b00);

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CTRL_RESET;
      pattern_q <= 32'h0000_0000;
      care_q <= 32'h0000_FFFF;
      width_q <= `WIDTH_RESET;
      int_div_q <= `DIV_RESET;
      pre_div_q <= `DIV_RESET;
      post_div_q <= `DIV_RESET;
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      s_axi_awready <= !aw_has && !s_axi_awready;
      s_axi_wready  <= !w_has && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wmap ? 2'b00 : 2'b10;
        case (wa)
          `OFF_CTRL:     ctrl_q <= merge(ctrl_q, wd, ws);
          `OFF_PATTERN:  pattern_q <= merge(pattern_q, wd, ws);
          `OFF_CARE:     care_q <= merge(care_q, wd, ws);
          `OFF_WIDTH:    width_q <= merge(width_q, wd, ws);
          `OFF_INT_DIV:  int_div_q <= merge(int_div_q, wd, ws);
          `OFF_PRE_DIV:  pre_div_q <= merge(pre_div_q, wd, ws);
          `OFF_POST_DIV: post_div_q <= merge(post_div_q, wd, ws);
          default: ;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `OFF_CTRL:       s_axi_rdata <= ctrl_q;
          `OFF_PATTERN:    s_axi_rdata <= pattern_q;
          `OFF_CARE:       s_axi_rdata <= care_q;
          `OFF_WIDTH:      s_axi_rdata <= width_q;
          `OFF_INT_DIV:    s_axi_rdata <= int_div_q;
          `OFF_PRE_DIV:    s_axi_rdata <= pre_div_q;
          `OFF_POST_DIV:   s_axi_rdata <= post_div_q;
          `OFF_STATUS:     s_axi_rdata <= {26'h0, pstate_q, post_rate, busy_q, trig_pend_q, lvl};
          `OFF_PERIOD:     s_axi_rdata <= period_q; // RULE_10
          `OFF_SCAN_WORDS: s_axi_rdata <= {30'h0, scan_words};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* trig_map.vh */
// register map, field positions, reset values and timing constants of the trigger and scan clock
`ifndef TRIG_MAP_VH
`define TRIG_MAP_VH
`define OFF_CTRL        8'h00
`define OFF_PATTERN     8'h04
`define OFF_CARE        8'h08
`define OFF_WIDTH       8'h0C
`define OFF_INT_DIV     8'h10
`define OFF_PRE_DIV     8'h14
`define OFF_POST_DIV    8'h18
`define OFF_STATUS      8'h1C
`define OFF_PERIOD      8'h20
`define OFF_SCAN_WORDS  8'h24
`define CTRL_TRIG_TYPE  1:0
`define CTRL_PULSE_SRC  2
`define CTRL_PULSE_MAX  3
`define CTRL_PAT_COND   5:4
`define CTRL_EXT_CLK    6
`define CTRL_LO_EN      7
`define CTRL_HI_EN      8
`define CTRL_ARM        9
`define CTRL_PREPOST    10
`define CTRL_PRESCALE   23:16
`define TT_NONE         2'd0
`define TT_PULSE        2'd1
`define TT_PATTERN      2'd2
`define COND_EQ         2'd0
`define COND_NE         2'd1
`define COND_GT         2'd2
`define COND_LT         2'd3
`define CTRL_RESET      32'h0001_0000
`define WIDTH_RESET     32'h0000_000D
`define DIV_RESET       32'h0000_30D4
`define WIDTH_MIN_NS    100
`define WIDTH_MAX_MS    800
`define CLK_MHZ         125
`define TB_MHZ          20
`define SCAN_WORD_NS    1000
`endif

/* acq_trigger_asserts.sv */
// port assertions for the trigger and scan clock block
`timescale 1ns/1ps
module acq_trigger_asserts (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        scan_start,
  input wire        trigger,
  input wire        post_rate,
  input wire [15:0] period_count_low_word,
  input wire [15:0] period_count_high_word,
  input wire [1:0]  scan_words
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer; s_wr_taken |=> s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_rd_answer; s_rd_taken |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_b_cause; $rose(s_axi_bvalid) |-> $past(s_axi_wvalid && s_axi_wready); endproperty
  a_b_cause: assert property (p_b_cause) else $error("write answer without data");
  property p_r_cause; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
  a_r_cause: assert property (p_r_cause) else $error("read answer without request");
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
  property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_once: assert property (p_r_once) else $error("read answer repeated");
  property p_start_pulse; scan_start |=> !scan_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("scan start too long");
  property p_trig_pulse; trigger |=> !trigger; endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");
  // counter words may only move with a scan start, so each scan sees one snapshot
  property p_words_hold;
    !$stable({period_count_low_word, period_count_high_word, scan_words})
      |-> scan_start || $past(scan_start);
  endproperty
  a_words_hold: assert property (p_words_hold) else $error("words moved mid scan");
  property p_post_rise; $rose(post_rate) |-> scan_start || $past(scan_start); endproperty
  a_post_rise: assert property (p_post_rise) else $error("rate change off scan");
endmodule
bind acq_trigger acq_trigger_asserts i_acq_trigger_asserts (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .scan_start(scan_start), .trigger(trigger), .post_rate(post_rate),
  .period_count_low_word(period_count_low_word),
  .period_count_high_word(period_count_high_word), .scan_words(scan_words));

/* ext_pulse_train.sv */
// external ttl scan clock source, still low between bursts
`timescale 1ns/1ps
module ext_pulse_train #(
  parameter int HALF_NS = 240
) (
  input  wire logic       start,
  input  wire logic [9:0] n_edges,
  output logic            ext_clk,
  output logic            busy
);
  initial begin
    ext_clk = 1'b0;
    busy = 1'b0;
  end
  always @(posedge start) begin
    busy = 1'b1;
    repeat (n_edges) begin
      #(HALF_NS) ext_clk = 1'b1;
      #(HALF_NS) ext_clk = 1'b0;
    end
    busy = 1'b0;
  end
endmodule

/* test_acquisition_trigger_and_scan_clock.sv */
// self-checking bench for the trigger and scan clock block
`timescale 1ns/1ps
`include "trig_map.vh"
module test_acquisition_trigger_and_scan_clock;
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  reg         s_axi_rready, ch1_above, pulse_above, scan_done, start, s, hi;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr, n;
  reg  [31:0] s_axi_wdata, q;
  reg  [15:0] dig_in, p, m, v;
  reg  [9:0]  edges;
  reg  [1:0]  r, c;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        ext_clk, ebusy, scan_start, trigger, post_rate;
  wire [1:0]  s_axi_bresp, s_axi_rresp, scan_words;
  wire [31:0] s_axi_rdata;
  wire [15:0] period_count_low_word, period_count_high_word;
  integer     n_errors, n_tests, n_trig, n_scan, seed, i, j, k;
  acq_trigger #(.WIDTH_MAX_CYC(1000)) i_acq_trigger (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ch1_above(ch1_above), .pulse_above(pulse_above), .dig_in(dig_in), .ext_clk(ext_clk),
    .scan_done(scan_done), .scan_start(scan_start), .trigger(trigger), .post_rate(post_rate),
    .period_count_low_word(period_count_low_word),
    .period_count_high_word(period_count_high_word), .scan_words(scan_words));
  ext_pulse_train i_ext_pulse_train (.start(start), .n_edges(edges), .ext_clk(ext_clk),
    .busy(ebusy));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // stand-in scan engine finishes at once so busy never blocks a scan
  always @(posedge aclk) begin
    scan_done <= scan_start;
    if (!aresetn) begin
      n_trig <= 0;
      n_scan <= 0;
    end else begin
      if (trigger === 1'b1) n_trig <= n_trig + 1;
      if (scan_start === 1'b1) n_scan <= n_scan + 1;
    end
  end
  function [31:0] mk(input [1:0] tt, input sr, mx, input [1:0] cd, input ex, lo, h, ar,
                     input [7:0] ps);
    mk = {8'h00, ps, 5'h00, 1'b0, ar, h, lo, ex, cd, mx, sr, tt};
  endfunction
  function exp_pat(input [1:0] cd, input [15:0] val, pat, care);
    case (cd)
      `COND_EQ: exp_pat = ((val ^ pat) & care) == 16'h0000;
      `COND_NE: exp_pat = ((val ^ pat) & care) != 16'h0000;
      `COND_GT: exp_pat = val > pat;
      default:  exp_pat = val < pat;
    endcase
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task close_out;
    begin
      if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // one bus transfer; handshakes judged mid-cycle, released just after the taking edge
  task xfer(input we, input [7:0] a, input [31:0] d, output [31:0] rd, output [1:0] rs);
    reg ha, hw, hr, hd;
    begin
      @(posedge aclk);
      if (we) begin
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
      end else begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
      end
      hd = 1'b0;
      while (!hd) begin
        @(negedge aclk);
        ha = s_axi_awvalid & s_axi_awready;
        hw = s_axi_wvalid & s_axi_wready;
        hr = s_axi_arvalid & s_axi_arready;
        hd = we ? s_axi_bvalid : s_axi_rvalid;
        rd = s_axi_rdata;
        rs = we ? s_axi_bresp : s_axi_rresp;
        @(posedge aclk);
        if (ha) s_axi_awvalid <= 1'b0;
        if (hw) s_axi_wvalid <= 1'b0;
        if (hr) s_axi_arvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
    end
  endtask
  task arm_cfg(input [31:0] cfg);
    begin
      xfer(1'b1, `OFF_CTRL, cfg & 32'hffff_fdff, q, r);
      repeat (4) @(posedge aclk);
      k = n_trig;
      xfer(1'b1, `OFF_CTRL, cfg, q, r);
    end
  endtask
  initial begin
    repeat (90000) @(posedge aclk);
    n_errors = n_errors + 1;
    close_out;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {ch1_above, pulse_above, start, s_axi_awaddr, s_axi_araddr} = 19'h0_0000;
    {s_axi_wdata, dig_in, edges} = 58'h0;
    {n_errors, n_tests, seed} = {32'd0, 32'd0, 32'd59};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    xfer(1'b0, `OFF_CTRL, 0, q, r);
    chk(q, `CTRL_RESET);
    xfer(1'b0, `OFF_WIDTH, 0, q, r);
    chk(q, `WIDTH_RESET);
    xfer(1'b0, `OFF_PRE_DIV, 0, q, r);
    chk(q, `DIV_RESET);
    xfer(1'b0, `OFF_CARE, 0, q, r);
    chk(q, 32'h0000_ffff);
    xfer(1'b0, 8'h40, 0, q, r);
    chk(r, 2'b10);
    xfer(1'b1, 8'h40, 32'h1234_5678, q, r);
    chk(r, 2'b10);
    for (i = 0; i < 12; i = i + 1) begin
      c = i[1:0];
      p = 16'($random(seed));
      m = 16'($random(seed));
      v = i[2] ? ((p & m) | (16'($random(seed)) & ~m)) : 16'($random(seed));
      xfer(1'b1, `OFF_PATTERN, {16'h0000, p}, q, r);
      xfer(1'b1, `OFF_CARE, {16'h0000, m}, q, r);
      dig_in <= v;
      arm_cfg(mk(`TT_PATTERN, 1'b0, 1'b0, c, 1'b0, 1'b0, 1'b0, 1'b1, 8'h01));
      repeat (10) @(posedge aclk);
      chk(n_trig != k, exp_pat(c, v, p, m));
    end
    xfer(1'b1, `OFF_WIDTH, 32'h0000_0014, q, r);
    for (i = 0; i < 8; i = i + 1) begin
      s = 1'($random(seed));
      arm_cfg(mk(`TT_PULSE, s, i[1], 2'd0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h01));
      if (s ^ i[0]) pulse_above <= 1'b1;
      else ch1_above <= 1'b1;
      repeat (i[2] ? 40 : 5) @(posedge aclk);
      pulse_above <= 1'b0;
      ch1_above <= 1'b0;
      repeat (40) @(posedge aclk);
      chk(n_trig != k, !i[0] && (i[1] ? !i[2] : i[2]));
    end
    for (j = 0; j < 3; j = j + 1) begin
      n = (j == 0) ? 8'd1 : (j == 1) ? 8'd255 : 8'd2 + 8'({$random(seed)} % 8);
      hi = (j != 1);
      xfer(1'b1, `OFF_CTRL, mk(`TT_NONE, 1'b0, 1'b0, 2'd0, 1'b1, 1'b1, hi, 1'b1, n), q, r);
      k = n_scan;
      edges <= {n, 1'b0};
      start <= 1'b1;
      repeat (2) @(posedge aclk);
      start <= 1'b0;
      while (ebusy) @(posedge aclk);
      repeat (20) @(posedge aclk);
      chk(n_scan - k, 2);
      chk((period_count_low_word >= 16'd9) && (period_count_low_word <= 16'd11), 1);
      chk(period_count_high_word, 0);
      chk(scan_words, {hi, 1'b1});
    end
    k = n_scan;
    repeat (300) @(posedge aclk);
    chk(n_scan - k, 0);
    xfer(1'b1, `OFF_PRE_DIV, 32'h0000_0028, q, r);
    xfer(1'b1, `OFF_CTRL, mk(`TT_NONE, 1'b0, 1'b0, 2'd0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h01), q, r);
    k = n_scan;
    repeat (300) @(posedge aclk);
    chk((n_scan - k >= 7) && (n_scan - k <= 8), 1);
    // pre/post: always-true pattern, rate drops from 40 to 20 cycles after the trigger
    xfer(1'b1, `OFF_CARE, 32'h0000_0000, q, r);
    xfer(1'b1, `OFF_POST_DIV, 32'h0000_0014, q, r);
    arm_cfg(mk(`TT_PATTERN, 1'b0, 1'b0, `COND_EQ, 1'b0, 1'b1, 1'b1, 1'b1, 8'h01) | 32'h0000_0400);
    repeat (100) @(posedge aclk);
    chk(n_trig != k, 1);
    chk(post_rate, 1);
    k = n_scan;
    repeat (200) @(posedge aclk);
    chk((n_scan - k >= 9) && (n_scan - k <= 11), 1);
    close_out;
  end
endmodule
